/* File: sp_baud_gen.sv */
`default_nettype none
//==================================================================
// baud rate generator: one tick every eff_div+1 cycles
module sp_baud_gen (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic restart_i,
    input wire logic wide_i,
    input wire logic [15:0] divisor_i,
    // tick
    output logic tick_o
);
    logic [15:0] cnt_q;
    wire [15:0] eff_div;

    assign eff_div = wide_i ? divisor_i : {8'h00, divisor_i[7:0]};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 16'h0000;
            tick_o <= 1'b0;
        end else if (restart_i) begin
            cnt_q <= eff_div;
            tick_o <= 1'b0;
        end else if (cnt_q == 16'h0000) begin
            cnt_q <= eff_div;
            tick_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q - 16'h0001;
            tick_o <= 1'b0;
        end
    end

    //==================================================================
    // checks
    chk_restart_count: assert property (@(posedge clk_i) disable iff (rst_i)
        restart_i |=> (cnt_q == $past(eff_div)) && !tick_o)
        else $error("counter not restarted by divisor write");
    chk_high_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        (restart_i && !wide_i) |=> cnt_q[15:8] == 8'h00)
        else $error("upper divisor byte used while narrow");
endmodule : sp_baud_gen
`default_nettype wire

/* File: sp_pkg.sv */
`default_nettype none
//==================================================================
// serial port constants and types
package sp_pkg;
    // register byte offsets
    localparam logic [7:0] SP_OFF_TXCS = 8'h00;
    localparam logic [7:0] SP_OFF_RXD = 8'h04;
    localparam logic [7:0] SP_OFF_TXD = 8'h08;
    localparam logic [7:0] SP_OFF_DIVL = 8'h0C;
    localparam logic [7:0] SP_OFF_DIVH = 8'h10;
    localparam logic [7:0] SP_OFF_AUX = 8'h14;
    // auxiliary control/status bit positions
    localparam int SP_AUX_WIDE = 0;
    localparam int SP_AUX_CONTINUOUS_RECEIVE_ENABLE = 1;
    localparam int SP_AUX_SINGLE_RECEIVE_ENABLE = 2;
    localparam int SP_AUX_RX9 = 3;
    localparam int SP_AUX_R9D = 4;
    localparam int SP_AUX_RXRDY = 5;
    localparam int SP_AUX_TXRDY = 6;
    // reset values
    localparam logic [7:0] SP_TXCS_RST = 8'h00;
    localparam logic [3:0] SP_AUX_RST = 4'h0;
    localparam logic [7:0] SP_DIV_RST = 8'h00;
    localparam logic [8:0] SP_DATA_RST = 9'h000;
    // frame lengths in bits
    localparam logic [3:0] SP_BITS_8 = 4'h8;
    localparam logic [3:0] SP_BITS_9 = 4'h9;
    localparam logic [3:0] SP_BREAK_ZEROS = 4'hC;
    // baud ticks per serial bit, then ahb-lite transfer type and size codes
    localparam logic [4:0] SP_TPB_SLOW = 5'h10;
    localparam logic [4:0] SP_TPB_MID = 5'h04;
    localparam logic [4:0] SP_TPB_FAST = 5'h01;
    localparam logic [4:0] SP_TPB_SYNC = 5'h02;
    localparam logic [1:0] SP_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] SP_HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic clock_master_select;
        logic nine_bit_transmit_select;
        logic transmit_enable;
        logic sync_mode;
        logic break_send_request;
        logic high_speed_baud_select;
        logic shift_register_empty;
        logic transmit_ninth_bit;
    } sp_txcs_type;

    typedef enum logic [1:0] {
        SP_TX_IDLE = 2'h0,
        SP_TX_START = 2'h1,
        SP_TX_DATA = 2'h3,
        SP_TX_STOP = 2'h2
    } sp_tx_state_type;

    typedef enum logic [1:0] {
        SP_RX_IDLE = 2'h0,
        SP_RX_START = 2'h1,
        SP_RX_DATA = 2'h3,
        SP_RX_STOP = 2'h2
    } sp_rx_state_type;
endpackage : sp_pkg
`default_nettype wire

/* File: sp_remote.sv */
`default_nettype none
//==================================================================
// far-side serial transceiver, idle high, lsb first
module sp_remote #(
    parameter int BIT_CLKS = 8
) (
    // clock
    input wire logic clk_i,
    // serial lines
    input wire logic line_i,
    input wire logic [3:0] nbits_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] got_q[$];
    logic [11:0] d;
    int i;
    initial line_o = 1'b1;
    //==================================================================
    // receiver: start rechecked at half bit, then bit centres
    initial begin
        forever begin
            @(negedge line_i);
            repeat (BIT_CLKS / 2) @(posedge clk_i);
            if (line_i === 1'b0) begin
                d = '0;
                for (i = 0; i < int'(nbits_i); i++) begin
                    repeat (BIT_CLKS) @(posedge clk_i);
                    d[i] = line_i;
                end
                repeat (BIT_CLKS) @(posedge clk_i);
                got_q.push_back({line_i, d});
            end
        end
    end
    //==================================================================
    // sender: start, eight data bits, stop
    task automatic send(input logic [7:0] b);
        line_o <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk_i);
        for (int k = 0; k < 8; k++) begin
            line_o <= b[k];
            repeat (BIT_CLKS) @(posedge clk_i);
        end
        line_o <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk_i);
    endtask : send
endmodule : sp_remote
`default_nettype wire

/* File: sp_serial_port.sv */
`default_nettype none
//==================================================================
// Summary of operation
// - in sync mode either receive enable overrides transmit enable
// - receive data register is read-only, eight low bits of character
// - received character and ninth bit double buffered while next shifts in
// - transmit data and ninth bit double buffered, refilled once shifting starts
// - any divisor write restarts the baud generator counter
// - divisor split into low byte 7..0 and high byte 15..8
// - high divisor byte ignored unless wide divisor on; its write restarts
module sp_serial_port (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // serial pins
    input wire logic rx_i,
    output logic tx_o,
    output logic sclk_o,
    output logic sclk_oe_n_o
);
    //==================================================================
    // bus decode
    logic dp_wr_q;
    logic [7:0] dp_off_q;
    wire ap_take;
    wire [7:0] ap_off;
    wire [7:0] wdat;
    wire wr_txcs;
    wire wr_txd;
    wire wr_divl;
    wire wr_divh;
    wire wr_aux;
    wire rx_rd;
    logic [7:0] rd_mux;

    assign ap_take = hsel_i & hready_i & (htrans_i == sp_pkg::SP_HTRANS_NONSEQ)
        & (hsize_i == sp_pkg::SP_HSIZE_WORD) & (haddr_i[31:8] == 24'h000000);
    assign ap_off = haddr_i[7:0];
    assign wdat = hwdata_i[7:0];
    assign wr_txcs = dp_wr_q & (dp_off_q == sp_pkg::SP_OFF_TXCS);
    assign wr_txd = dp_wr_q & (dp_off_q == sp_pkg::SP_OFF_TXD);
    assign wr_divl = dp_wr_q & (dp_off_q == sp_pkg::SP_OFF_DIVL);
    assign wr_divh = dp_wr_q & (dp_off_q == sp_pkg::SP_OFF_DIVH);
    assign wr_aux = dp_wr_q & (dp_off_q == sp_pkg::SP_OFF_AUX);
    // receive data has no write path
    assign rx_rd = ap_take & !hwrite_i & (ap_off == sp_pkg::SP_OFF_RXD);
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    //==================================================================
    // registers
    sp_pkg::sp_txcs_type txcs_q;
    logic [3:0] aux_q;
    logic [7:0] div_lo_q;
    logic [7:0] div_hi_q;
    logic [8:0] tx_buf_q;
    logic tx_full_q;
    logic [8:0] rx_hold_q;
    logic rx_full_q;
    wire sync;
    wire master;
    wire tx_allowed;
    wire rx_on;
    wire tx_empty;
    wire brk_done;
    wire single_receive_enable_done;
    wire [7:0] txcs_rd;
    wire [7:0] aux_rd;

    assign sync = txcs_q.sync_mode;
    assign master = txcs_q.clock_master_select;
    // receive wins over transmit in sync mode
    assign tx_allowed = txcs_q.transmit_enable
        & !(sync & (aux_q[sp_pkg::SP_AUX_SINGLE_RECEIVE_ENABLE] | aux_q[sp_pkg::SP_AUX_CONTINUOUS_RECEIVE_ENABLE]));
    assign rx_on = sync ? (master & (aux_q[sp_pkg::SP_AUX_SINGLE_RECEIVE_ENABLE] | aux_q[sp_pkg::SP_AUX_CONTINUOUS_RECEIVE_ENABLE]))
        : aux_q[sp_pkg::SP_AUX_CONTINUOUS_RECEIVE_ENABLE];
    assign txcs_rd = {txcs_q[7:2], tx_empty, txcs_q.transmit_ninth_bit};
    assign aux_rd = {1'b0, !tx_full_q, rx_full_q, rx_hold_q[8], aux_q};
    assign rd_mux = (ap_off == sp_pkg::SP_OFF_TXCS) ? txcs_rd
        : (ap_off == sp_pkg::SP_OFF_RXD) ? rx_hold_q[7:0]
        : (ap_off == sp_pkg::SP_OFF_TXD) ? tx_buf_q[7:0]
        : (ap_off == sp_pkg::SP_OFF_DIVL) ? div_lo_q
        : (ap_off == sp_pkg::SP_OFF_DIVH) ? div_hi_q
        : (ap_off == sp_pkg::SP_OFF_AUX) ? aux_rd
        : 8'h00;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dp_wr_q <= 1'b0;
            dp_off_q <= 8'h00;
            hrdata_o <= 32'h00000000;
        end else begin
            if (hready_i) begin
                dp_wr_q <= ap_take & hwrite_i;
                dp_off_q <= ap_off;
            end
            if (ap_take & !hwrite_i) begin
                hrdata_o <= {24'h000000, rd_mux};
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            txcs_q <= sp_pkg::SP_TXCS_RST;
            aux_q <= sp_pkg::SP_AUX_RST;
            div_lo_q <= sp_pkg::SP_DIV_RST;
            div_hi_q <= sp_pkg::SP_DIV_RST;
        end else begin
            if (wr_txcs) begin
                txcs_q <= {wdat[7:2], 1'b0, wdat[0]};
            end else if (brk_done) begin
                txcs_q.break_send_request <= 1'b0;
            end
            if (wr_aux) begin
                aux_q <= wdat[3:0];
            end else if (single_receive_enable_done) begin
                aux_q[sp_pkg::SP_AUX_SINGLE_RECEIVE_ENABLE] <= 1'b0;
            end
            if (wr_divl) begin
                div_lo_q <= wdat;
            end
            if (wr_divh) begin
                div_hi_q <= wdat;
            end
        end
    end

    //==================================================================
    // baud timing
    wire baud_tick;
    logic [4:0] tpb;
    wire [4:0] half;

    assign tpb = sync ? sp_pkg::SP_TPB_SYNC
        : (txcs_q.high_speed_baud_select & aux_q[sp_pkg::SP_AUX_WIDE]) ? sp_pkg::SP_TPB_FAST
        : (txcs_q.high_speed_baud_select | aux_q[sp_pkg::SP_AUX_WIDE]) ? sp_pkg::SP_TPB_MID
        : sp_pkg::SP_TPB_SLOW;
    assign half = tpb >> 1;

    sp_baud_gen u_baud (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(wr_divl | wr_divh),
        .wide_i(aux_q[sp_pkg::SP_AUX_WIDE]),
        .divisor_i({div_hi_q, div_lo_q}),
        .tick_o(baud_tick)
    );

    //==================================================================
    // transmitter
    sp_pkg::sp_tx_state_type tx_st_q;
    logic [8:0] tsr_q;
    logic [3:0] tbit_q;
    logic [4:0] tcnt_q;
    logic brk_run_q;
    logic tx_q;
    wire tx_go;
    wire bit_end;
    wire [3:0] tx_nbits;
    wire tx_d;

    assign tx_empty = (tx_st_q == sp_pkg::SP_TX_IDLE);
    assign tx_go = tx_allowed & tx_full_q & tx_empty;
    assign bit_end = baud_tick & (tcnt_q == tpb - 5'h01);
    assign tx_nbits = brk_run_q ? sp_pkg::SP_BREAK_ZEROS
        : txcs_q.nine_bit_transmit_select ? sp_pkg::SP_BITS_9 : sp_pkg::SP_BITS_8;
    assign brk_done = (tx_st_q == sp_pkg::SP_TX_STOP) & bit_end & brk_run_q;
    assign tx_d = (tx_st_q == sp_pkg::SP_TX_START) ? 1'b0
        : (tx_st_q == sp_pkg::SP_TX_DATA) ? (!brk_run_q & tsr_q[0])
        : 1'b1;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_buf_q <= sp_pkg::SP_DATA_RST;
            tx_full_q <= 1'b0;
        end else begin
            if (wr_txd) begin
                tx_buf_q <= {txcs_q.transmit_ninth_bit, wdat};
            end
            tx_full_q <= wr_txd | (tx_full_q & !tx_go);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_st_q <= sp_pkg::SP_TX_IDLE;
            tsr_q <= sp_pkg::SP_DATA_RST;
            tbit_q <= 4'h0;
            tcnt_q <= 5'h00;
            brk_run_q <= 1'b0;
            tx_q <= 1'b1;
        end else begin
            tx_q <= tx_d;
            if (baud_tick) begin
                tcnt_q <= bit_end ? 5'h00 : tcnt_q + 5'h01;
            end
            case (tx_st_q)
                sp_pkg::SP_TX_IDLE: begin
                    tcnt_q <= 5'h00;
                    if (tx_go) begin
                        tsr_q <= tx_buf_q;
                        tbit_q <= 4'h0;
                        brk_run_q <= !sync & txcs_q.break_send_request;
                        tx_st_q <= sync ? sp_pkg::SP_TX_DATA : sp_pkg::SP_TX_START;
                    end
                end
                sp_pkg::SP_TX_START: begin
                    if (bit_end) begin
                        tx_st_q <= sp_pkg::SP_TX_DATA;
                    end
                end
                sp_pkg::SP_TX_DATA: begin
                    if (bit_end) begin
                        tsr_q <= {1'b0, tsr_q[8:1]};
                        tbit_q <= tbit_q + 4'h1;
                        if (tbit_q == tx_nbits - 4'h1) begin
                            tx_st_q <= sync ? sp_pkg::SP_TX_IDLE : sp_pkg::SP_TX_STOP;
                        end
                    end
                end
                sp_pkg::SP_TX_STOP: begin
                    if (bit_end) begin
                        tx_st_q <= sp_pkg::SP_TX_IDLE;
                        brk_run_q <= 1'b0;
                    end
                end
                default: tx_st_q <= sp_pkg::SP_TX_IDLE;
            endcase
        end
    end
    assign tx_o = tx_q;

    //==================================================================
    // receiver
    sp_pkg::sp_rx_state_type rx_st_q;
    logic [8:0] rsh_q;
    logic [3:0] rbit_q;
    logic [4:0] rcnt_q;
    logic sclk_q;
    wire [3:0] rx_nbits;
    wire r_sample;
    wire rx_done;
    wire rx_load;
    wire [8:0] rx_char;
    wire [8:0] rx_sync_char;

    assign rx_nbits = aux_q[sp_pkg::SP_AUX_RX9] ? sp_pkg::SP_BITS_9 : sp_pkg::SP_BITS_8;
    assign r_sample = baud_tick & (rcnt_q == tpb - 5'h01);
    assign rx_done = sync ? ((rx_st_q == sp_pkg::SP_RX_DATA) & r_sample
            & (rbit_q == rx_nbits - 4'h1))
        : ((rx_st_q == sp_pkg::SP_RX_STOP) & r_sample);
    // a read in the same cycle frees the holding stage
    assign rx_load = rx_done & (!rx_full_q | rx_rd);
    assign single_receive_enable_done = rx_done & sync & aux_q[sp_pkg::SP_AUX_SINGLE_RECEIVE_ENABLE];
    assign rx_char = aux_q[sp_pkg::SP_AUX_RX9] ? rsh_q : {1'b0, rsh_q[8:1]};
    // sync load comes with the last bit still on the pin
    assign rx_sync_char = aux_q[sp_pkg::SP_AUX_RX9] ? {rx_i, rsh_q[8:1]}
        : {1'b0, rx_i, rsh_q[8:2]};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_hold_q <= sp_pkg::SP_DATA_RST;
            rx_full_q <= 1'b0;
        end else begin
            if (rx_load) begin
                rx_hold_q <= sync ? rx_sync_char : rx_char;
            end
            rx_full_q <= rx_load | (rx_full_q & !rx_rd);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_st_q <= sp_pkg::SP_RX_IDLE;
            rsh_q <= sp_pkg::SP_DATA_RST;
            rbit_q <= 4'h0;
            rcnt_q <= 5'h00;
        end else begin
            if (baud_tick) begin
                rcnt_q <= (rcnt_q == tpb - 5'h01) ? 5'h00 : rcnt_q + 5'h01;
            end
            case (rx_st_q)
                sp_pkg::SP_RX_IDLE: begin
                    rcnt_q <= 5'h00;
                    rbit_q <= 4'h0;
                    if (rx_on & sync) begin
                        rx_st_q <= sp_pkg::SP_RX_DATA;
                    end else if (rx_on & !rx_i) begin
                        rx_st_q <= sp_pkg::SP_RX_START;
                    end
                end
                sp_pkg::SP_RX_START: begin
                    if (baud_tick & (rcnt_q == half)) begin
                        rcnt_q <= 5'h00;
                        rx_st_q <= rx_i ? sp_pkg::SP_RX_IDLE : sp_pkg::SP_RX_DATA;
                    end
                end
                sp_pkg::SP_RX_DATA: begin
                    if (r_sample) begin
                        rsh_q <= {rx_i, rsh_q[8:1]};
                        rbit_q <= rbit_q + 4'h1;
                        if (rbit_q == rx_nbits - 4'h1) begin
                            rx_st_q <= sync ? sp_pkg::SP_RX_IDLE : sp_pkg::SP_RX_STOP;
                        end
                    end
                end
                sp_pkg::SP_RX_STOP: begin
                    if (r_sample) begin
                        rx_st_q <= sp_pkg::SP_RX_IDLE;
                    end
                end
                default: rx_st_q <= sp_pkg::SP_RX_IDLE;
            endcase
        end
    end

    // sync clock: low in first half of a bit, high in second
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sync & master & ((!tx_empty & (tcnt_q >= half))
                | ((rx_st_q != sp_pkg::SP_RX_IDLE) & (rcnt_q >= half)));
        end
    end
    assign sclk_o = sclk_q;
    assign sclk_oe_n_o = !(sync & master);

    //==================================================================
    // checks
    chk_sync_rx_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        (sync && (aux_q[sp_pkg::SP_AUX_SINGLE_RECEIVE_ENABLE] || aux_q[sp_pkg::SP_AUX_CONTINUOUS_RECEIVE_ENABLE])) |-> !tx_go)
        else $error("transmit started while sync receive enabled");
    chk_rxd_readonly: assert property (@(posedge clk_i) disable iff (rst_i)
        !rx_load |=> $stable(rx_hold_q))
        else $error("receive data changed without a received character");
    chk_rx_hold_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        (rx_full_q && !rx_rd) |=> rx_full_q && (rx_hold_q == $past(rx_hold_q)))
        else $error("unread character lost");
    chk_rx_load_full: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_load |=> rx_full_q)
        else $error("loaded character not flagged");
    chk_tx_refill: assert property (@(posedge clk_i) disable iff (rst_i)
        (tx_go && !wr_txd) |=> !tx_full_q && (tsr_q == $past(tx_buf_q)))
        else $error("buffer not moved to shift register");
    chk_div_bytes: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_divh |=> (div_hi_q == $past(wdat)) && $stable(div_lo_q))
        else $error("divisor high byte write misplaced");
    chk_break_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (tx_st_q == sp_pkg::SP_TX_DATA && brk_run_q) |=> !tx_o)
        else $error("break frame sent a one");
    chk_break_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (brk_done && !wr_txcs) |=> !txcs_q.break_send_request && tx_empty)
        else $error("break request not cleared");
    chk_ninth_sent: assert property (@(posedge clk_i) disable iff (rst_i)
        (tx_go && txcs_q.nine_bit_transmit_select && !sync && !txcs_q.break_send_request)
        |=> (tsr_q[8] == $past(tx_buf_q[8])))
        else $error("ninth bit not queued");
    cov_char_sent: cover property (@(posedge clk_i) disable iff (rst_i)
        tx_st_q == sp_pkg::SP_TX_STOP ##1 tx_empty);
    cov_char_recv: cover property (@(posedge clk_i) disable iff (rst_i) rx_load);
    cov_break_done: cover property (@(posedge clk_i) disable iff (rst_i) brk_done);
    cov_rx_overrun: cover property (@(posedge clk_i) disable iff (rst_i)
        rx_done && rx_full_q && !rx_rd);
endmodule : sp_serial_port
`default_nettype wire

/* File: sp_serial_port_bench.sv */
`default_nettype none
module sp_serial_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
    } sp_row_type;
    logic clk_i, rst_i, hsel, hwrite, hreadyout, hresp, rx_line, tx_line, sclk, sclk_oe_n;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] nbits;
    int num_errors = 0;
    int checks = 0;
    // high byte kept nonzero with wide divisor off
    sp_row_type rows[6] = '{
        '{sp_pkg::SP_OFF_TXCS, 8'h44, 8'h46},
        '{sp_pkg::SP_OFF_DIVL, 8'h01, 8'h01},
        '{sp_pkg::SP_OFF_DIVH, 8'hA5, 8'hA5},
        '{sp_pkg::SP_OFF_AUX, 8'h02, 8'h42},
        '{sp_pkg::SP_OFF_RXD, 8'h5A, 8'h00},
        '{8'h18, 8'hFF, 8'h00}};

    sp_serial_port uut (
        .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
        .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .rx_i(rx_line),
        .tx_o(tx_line), .sclk_o(sclk), .sclk_oe_n_o(sclk_oe_n));
    sp_remote #(.BIT_CLKS(8)) peer (
        .clk_i(clk_i), .line_i(tx_line), .nbits_i(nbits), .line_o(rx_line));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    //==================================================================
    // reporting
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : compare

    //==================================================================
    // ahb-lite single word transfer
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100) begin
            num_errors++;
            end_of_test();
        end
    endtask : wait_ready

    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] wd,
                       output logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= sp_pkg::SP_HTRANS_NONSEQ;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        wait_ready();
        d = hrdata;
    endtask : bus

    task automatic wait_frames(input int n);
        int t;
        t = 0;
        while (peer.got_q.size() < n && t < 3000) begin
            @(posedge clk_i);
            t++;
        end
        if (t >= 3000) begin
            num_errors++;
            end_of_test();
        end
        repeat (16) @(posedge clk_i);
    endtask : wait_frames

    initial begin
        repeat (100000) @(posedge clk_i);
        num_errors++;
        end_of_test();
    end

    //==================================================================
    // main sequence
    initial begin
        rst_i = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = sp_pkg::SP_HSIZE_WORD;
        hwdata = 32'h00000000;
        nbits = 4'h8;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i]) begin
            bus(rows[i].addr, 1'b1, rows[i].wdata, rd);
            bus(rows[i].addr, 1'b0, 8'h00, rd);
            compare("register", {24'h000000, rows[i].rdata}, rd);
        end
        // second character shifts in while the first is read
        fork
            begin
                peer.send(8'h96);
                peer.send(8'h69);
            end
        join_none
        repeat (100) @(posedge clk_i);
        bus(sp_pkg::SP_OFF_RXD, 1'b0, 8'h00, rd);
        compare("rx first", 32'h00000096, rd);
        repeat (100) @(posedge clk_i);
        bus(sp_pkg::SP_OFF_RXD, 1'b0, 8'h00, rd);
        compare("rx second", 32'h00000069, rd);
        // back-to-back writes while the first shifts out
        bus(sp_pkg::SP_OFF_TXCS, 1'b1, 8'h24, rd);
        bus(sp_pkg::SP_OFF_TXD, 1'b1, 8'h3C, rd);
        bus(sp_pkg::SP_OFF_TXD, 1'b1, 8'hC3, rd);
        wait_frames(2);
        compare("tx first", 32'h0000103C, 32'(peer.got_q[0]));
        compare("tx second", 32'h000010C3, 32'(peer.got_q[1]));
        peer.got_q.delete();
        nbits <= 4'h9;
        bus(sp_pkg::SP_OFF_TXCS, 1'b1, 8'h65, rd);
        bus(sp_pkg::SP_OFF_TXD, 1'b1, 8'h81, rd);
        wait_frames(1);
        compare("tx nine", 32'h00001181, 32'(peer.got_q[0]));
        peer.got_q.delete();
        nbits <= 4'hC;
        bus(sp_pkg::SP_OFF_TXCS, 1'b1, 8'h2C, rd);
        bus(sp_pkg::SP_OFF_TXD, 1'b1, 8'h55, rd);
        wait_frames(1);
        compare("break frame", 32'h00001000, 32'(peer.got_q[0]));
        bus(sp_pkg::SP_OFF_TXCS, 1'b0, 8'h00, rd);
        compare("break flag", 32'h00000026, rd);
        // sync master with receive enabled holds the transmitter
        bus(sp_pkg::SP_OFF_TXCS, 1'b1, 8'hB0, rd);
        bus(sp_pkg::SP_OFF_TXD, 1'b1, 8'h11, rd);
        repeat (40) @(posedge clk_i);
        bus(sp_pkg::SP_OFF_TXCS, 1'b0, 8'h00, rd);
        compare("sync held", 32'h000000B2, rd);
        bus(sp_pkg::SP_OFF_AUX, 1'b1, 8'h00, rd);
        for (int n = 0; n < 60 && rd[1] !== 1'b0; n++) begin
            bus(sp_pkg::SP_OFF_TXCS, 1'b0, 8'h00, rd);
        end
        compare("sync start", 32'h000000B0, rd);
        compare("sync clock enable", 32'h00000000, {31'h00000000, sclk_oe_n});
        for (int n = 0; n < 16 && sclk !== 1'b1; n++) begin
            @(posedge clk_i);
        end
        compare("sync clock", 32'h00000001, {31'h00000000, sclk});
        // reset in mid-run
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(sp_pkg::SP_OFF_TXCS, 1'b0, 8'h00, rd);
        compare("reset ctrl", 32'h00000002, rd);
        bus(sp_pkg::SP_OFF_DIVH, 1'b0, 8'h00, rd);
        compare("reset divh", 32'h00000000, rd);
        compare("reset pins", 32'h00000006, {29'h00000000, tx_line, sclk_oe_n, sclk});
        compare("response", 32'h00000000, {31'h00000000, hresp});
        // wide divisor, both speed bits: one tick per bit, eight clocks per tick
        repeat (120) @(posedge clk_i);
        peer.got_q.delete();
        nbits <= 4'h8;
        bus(sp_pkg::SP_OFF_DIVL, 1'b1, 8'h07, rd);
        bus(sp_pkg::SP_OFF_AUX, 1'b1, 8'h01, rd);
        bus(sp_pkg::SP_OFF_TXCS, 1'b1, 8'h24, rd);
        bus(sp_pkg::SP_OFF_DIVL, 1'b1, 8'h07, rd);
        bus(sp_pkg::SP_OFF_TXD, 1'b1, 8'hA7, rd);
        wait_frames(1);
        compare("wide frame", 32'h000010A7, 32'(peer.got_q[0]));
        end_of_test();
    end
endmodule : sp_serial_port_bench
`default_nettype wire
